// ==== hw/abort_dma_ctrl.sv ====
/*
  Abort cause register, slave data NACK control and DMA request logic.
  Assumes the bus engine, enable register, status register and FIFOs run
  on sys_clk and hand their signals over without synchronisers.
*/
`timescale 1ns/1ps

module abort_dma_ctrl
  import abort_dma_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   reset_n,
  input  wire reg_req_t               reg_req,
  output logic [31:0]                 reg_rdata,
  input  wire abort_events_t          abort_events,
  input  wire logic                   sbyte_norestart_cause,
  input  wire logic                   abort_clear_read,
  input  wire logic                   all_irq_clear_read,
  input  wire logic                   controller_enable,
  input  wire logic                   slave_active,
  input  wire logic                   slave_receiver,
  input  wire logic [COUNT_WIDTH-1:0] tx_fifo_count,
  input  wire logic [COUNT_WIDTH-1:0] rx_fifo_count,
  output dma_req_t                    dma_req,
  output logic                        tx_abort_event,
  output logic                        slave_data_nack,
  output logic                        irq
);

  logic [CAUSE_WIDTH-1:0] abort_cause_reg;
  logic                   bit9_cleared_reg;
  logic                   nack_ctrl_reg;
  logic                   tx_dma_en_reg;
  logic                   rx_dma_en_reg;
  logic [LEVEL_WIDTH-1:0] tx_level_reg;
  logic [LEVEL_WIDTH-1:0] rx_level_reg;
  logic [IRQ_WIDTH-1:0]   irq_status_reg;
  logic [IRQ_WIDTH-1:0]   irq_mask_reg;
  logic [IRQ_WIDTH-1:0]   irq_events;
  logic [CAUSE_WIDTH-1:0] cause_events;
  logic                   cause_clear;
  logic                   nack_write;
  logic                   nack_refused;
  logic                   tx_cond;
  logic                   rx_cond;

  function automatic logic hit(input reg_req_t req, input logic [7:0] ofs, input logic is_wr);
    hit = (is_wr ? req.wr : req.rd) && (req.addr == ofs);
  endfunction

  assign cause_events = abort_events;
  assign cause_clear  = abort_clear_read || all_irq_clear_read;
  assign nack_write   = hit(reg_req, SLV_NACK_CTRL_OFS, 1'b1);
  assign nack_refused = nack_write && (controller_enable || slave_active);
  assign tx_cond      = tx_dma_en_reg && (tx_fifo_count <= {1'b0, tx_level_reg});
  assign rx_cond      = rx_dma_en_reg && (rx_fifo_count >= ({1'b0, rx_level_reg} + 4'h1));
  assign irq_events   = {nack_refused, |cause_events};

  // Causes 8..0: a new event in a clear cycle survives the clear
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      abort_cause_reg[8:0] <= 9'h000;
    end
    else if (cause_clear)
    begin
      abort_cause_reg[8:0] <= cause_events[8:0];
    end
    else
    begin
      abort_cause_reg[8:0] <= abort_cause_reg[8:0] | cause_events[8:0];
    end
  end

  // Bit 9 drops for one cycle on a clear, then returns while its cause stays
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      abort_cause_reg[9] <= 1'b0;
      bit9_cleared_reg   <= 1'b0;
    end
    else
    begin
      bit9_cleared_reg <= cause_clear && sbyte_norestart_cause;
      if (cause_clear)
      begin
        abort_cause_reg[9] <= 1'b0;
      end
      else if (cause_events[9] || (bit9_cleared_reg && sbyte_norestart_cause))
      begin
        abort_cause_reg[9] <= 1'b1;
      end
    end
  end

  // Guarded write; software is expected to poll activity first
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      nack_ctrl_reg <= REG_RESET[0];
    end
    else if (nack_write && !controller_enable && !slave_active)
    begin
      nack_ctrl_reg <= reg_req.wdata[NACK_BIT];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      slave_data_nack <= 1'b0;
    end
    else
    begin
      slave_data_nack <= nack_ctrl_reg && slave_receiver;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      tx_dma_en_reg <= REG_RESET[TX_DMA_EN_BIT];
      rx_dma_en_reg <= REG_RESET[RX_DMA_EN_BIT];
      tx_level_reg  <= REG_RESET[LEVEL_WIDTH-1:0];
      rx_level_reg  <= REG_RESET[LEVEL_WIDTH-1:0];
    end
    else
    begin
      if (hit(reg_req, DMA_CONTROL_OFS, 1'b1))
      begin
        tx_dma_en_reg <= reg_req.wdata[TX_DMA_EN_BIT];
        rx_dma_en_reg <= reg_req.wdata[RX_DMA_EN_BIT];
      end
      if (hit(reg_req, DMA_TX_LEVEL_OFS, 1'b1))
      begin
        tx_level_reg <= reg_req.wdata[LEVEL_WIDTH-1:0];
      end
      if (hit(reg_req, DMA_RX_LEVEL_OFS, 1'b1))
      begin
        rx_level_reg <= reg_req.wdata[LEVEL_WIDTH-1:0];
      end
    end
  end

  // Requests are levels; the DMA controller samples them, so one cycle lag is harmless
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      dma_req <= '0;
    end
    else
    begin
      dma_req.tx <= tx_cond;
      dma_req.rx <= rx_cond;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      tx_abort_event <= 1'b0;
    end
    else
    begin
      tx_abort_event <= |cause_events;
    end
  end

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      irq_status_reg <= REG_RESET[IRQ_WIDTH-1:0];
      irq_mask_reg   <= REG_RESET[IRQ_WIDTH-1:0];
    end
    else
    begin
      if (hit(reg_req, IRQ_STATUS_OFS, 1'b1))
      begin
        irq_status_reg <= (irq_status_reg & ~reg_req.wdata[IRQ_WIDTH-1:0]) | irq_events;
      end
      else
      begin
        irq_status_reg <= irq_status_reg | irq_events;
      end
      if (hit(reg_req, IRQ_MASK_OFS, 1'b1))
      begin
        irq_mask_reg <= reg_req.wdata[IRQ_WIDTH-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // Unmapped addresses read as zero
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      reg_rdata <= REG_RESET;
    end
    else if (!reg_req.rd)
    begin
      reg_rdata <= REG_RESET;
    end
    else if (reg_req.addr == ABORT_CAUSE_OFS)
    begin
      reg_rdata <= {22'h00_0000, abort_cause_reg};
    end
    else if (reg_req.addr == SLV_NACK_CTRL_OFS)
    begin
      reg_rdata <= {31'h0000_0000, nack_ctrl_reg};
    end
    else if (reg_req.addr == DMA_CONTROL_OFS)
    begin
      reg_rdata <= {30'h0000_0000, tx_dma_en_reg, rx_dma_en_reg};
    end
    else if (reg_req.addr == DMA_TX_LEVEL_OFS)
    begin
      reg_rdata <= {29'h0000_0000, tx_level_reg};
    end
    else if (reg_req.addr == DMA_RX_LEVEL_OFS)
    begin
      reg_rdata <= {29'h0000_0000, rx_level_reg};
    end
    else if (reg_req.addr == IRQ_STATUS_OFS)
    begin
      reg_rdata <= {30'h0000_0000, irq_status_reg};
    end
    else if (reg_req.addr == IRQ_MASK_OFS)
    begin
      reg_rdata <= {30'h0000_0000, irq_mask_reg};
    end
    else
    begin
      reg_rdata <= REG_RESET;
    end
  end

  property p_bit9_set;
    @(posedge sys_clk) disable iff (!reset_n)
    (abort_events.start_byte_without_restart && !cause_clear) |=> abort_cause_reg[9];
  endproperty
  a_bit9_set: assert property (p_bit9_set) else $error("bit 9 not set");

  property p_low_causes_set;
    @(posedge sys_clk) disable iff (!reset_n)
    cause_events[8:0] != 9'h000 |=>
      ((abort_cause_reg[8:0] & $past(cause_events[8:0])) == $past(cause_events[8:0]));
  endproperty
  a_low_causes_set: assert property (p_low_causes_set) else $error("cause lost");

  property p_clear_low;
    @(posedge sys_clk) disable iff (!reset_n)
    cause_clear |=> abort_cause_reg[8:0] == $past(cause_events[8:0]);
  endproperty
  a_clear_low: assert property (p_clear_low) else $error("clear failed");

  property p_bit9_reassert;
    @(posedge sys_clk) disable iff (!reset_n)
    (cause_clear && sbyte_norestart_cause) ##1 (sbyte_norestart_cause && !cause_clear)
      |-> !abort_cause_reg[9] ##1 abort_cause_reg[9];
  endproperty
  a_bit9_reassert: assert property (p_bit9_reassert) else $error("bit 9 not back");

  property p_nack_refused;
    @(posedge sys_clk) disable iff (!reset_n)
    (nack_write && (controller_enable || slave_active)) |=> $stable(nack_ctrl_reg);
  endproperty
  a_nack_refused: assert property (p_nack_refused) else $error("write not ignored");

  property p_nack_accepted;
    @(posedge sys_clk) disable iff (!reset_n)
    (nack_write && !controller_enable && !slave_active) |=>
      nack_ctrl_reg == $past(reg_req.wdata[0]);
  endproperty
  a_nack_accepted: assert property (p_nack_accepted) else $error("write lost");

  property p_nack_out;
    @(posedge sys_clk) disable iff (!reset_n)
    (slave_receiver && nack_ctrl_reg) |=> slave_data_nack;
  endproperty
  a_nack_out: assert property (p_nack_out) else $error("no data nack");

  property p_tx_req;
    @(posedge sys_clk) disable iff (!reset_n)
    (tx_dma_en_reg && tx_fifo_count <= {1'b0, tx_level_reg}) |=> dma_req.tx;
  endproperty
  a_tx_req: assert property (p_tx_req) else $error("tx request missing");

  property p_rx_req;
    @(posedge sys_clk) disable iff (!reset_n)
    (rx_dma_en_reg && rx_fifo_count > {1'b0, rx_level_reg}) |=> dma_req.rx;
  endproperty
  a_rx_req: assert property (p_rx_req) else $error("rx request missing");

  property p_req_drop;
    @(posedge sys_clk) disable iff (!reset_n)
    (!tx_dma_en_reg || !rx_dma_en_reg) |=>
      (!dma_req.tx || $past(tx_dma_en_reg)) && (!dma_req.rx || $past(rx_dma_en_reg));
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("request stuck");

  property p_tx_drop;
    @(posedge sys_clk) disable iff (!reset_n)
    !(tx_dma_en_reg && tx_fifo_count <= {1'b0, tx_level_reg}) |=> !dma_req.tx;
  endproperty
  a_tx_drop: assert property (p_tx_drop) else $error("tx request not dropped");

  property p_rx_drop;
    @(posedge sys_clk) disable iff (!reset_n)
    !(rx_dma_en_reg && rx_fifo_count > {1'b0, rx_level_reg}) |=> !dma_req.rx;
  endproperty
  a_rx_drop: assert property (p_rx_drop) else $error("rx request not dropped");

  property p_dma_ctrl_write;
    @(posedge sys_clk) disable iff (!reset_n)
    hit(reg_req, DMA_CONTROL_OFS, 1'b1) |=>
      {tx_dma_en_reg, rx_dma_en_reg} == $past(reg_req.wdata[TX_DMA_EN_BIT:RX_DMA_EN_BIT]);
  endproperty
  a_dma_ctrl_write: assert property (p_dma_ctrl_write) else $error("enable write lost");

  property p_abort_pulse;
    @(posedge sys_clk) disable iff (!reset_n)
    (|cause_events) |=> tx_abort_event;
  endproperty
  a_abort_pulse: assert property (p_abort_pulse) else $error("abort event missing");

  property p_irq;
    @(posedge sys_clk) disable iff (!reset_n)
    ##1 1'b1 |-> irq == |($past(irq_status_reg) & $past(irq_mask_reg));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  c_abort_clear: cover property (@(posedge sys_clk) disable iff (!reset_n)
    abort_cause_reg[3] ##1 cause_clear);
  c_bit9_back: cover property (@(posedge sys_clk) disable iff (!reset_n)
    (cause_clear && abort_cause_reg[9]) ##2 abort_cause_reg[9]);
  c_both_req: cover property (@(posedge sys_clk) disable iff (!reset_n)
    dma_req.tx && dma_req.rx);
  c_nack_refused: cover property (@(posedge sys_clk) disable iff (!reset_n) nack_refused);
  c_nack_out: cover property (@(posedge sys_clk) disable iff (!reset_n) slave_data_nack);

endmodule

// ==== inc/abort_dma_pkg.sv ====
/*
  Shared constants and carriers for the abort cause, slave data NACK and
  DMA request block. Assumes a 32-bit register port with byte offsets.
*/
package abort_dma_pkg;

  localparam logic [7:0]  ABORT_CAUSE_OFS   = 8'h80;
  localparam logic [7:0]  SLV_NACK_CTRL_OFS = 8'h84;
  localparam logic [7:0]  DMA_CONTROL_OFS   = 8'h88;
  localparam logic [7:0]  DMA_TX_LEVEL_OFS  = 8'h8C;
  localparam logic [7:0]  DMA_RX_LEVEL_OFS  = 8'h90;
  localparam logic [7:0]  IRQ_STATUS_OFS    = 8'hB0;
  localparam logic [7:0]  IRQ_MASK_OFS      = 8'hB4;

  localparam logic [31:0] REG_RESET         = 32'h0000_0000;

  localparam int          TX_DMA_EN_BIT     = 1;
  localparam int          RX_DMA_EN_BIT     = 0;
  localparam int          NACK_BIT          = 0;
  localparam int          CAUSE_WIDTH       = 10;
  localparam int          LEVEL_WIDTH       = 3;
  localparam int          COUNT_WIDTH       = 4;

  localparam int          IRQ_ABORT_BIT     = 0;
  localparam int          IRQ_NACK_REF_BIT  = 1;
  localparam int          IRQ_WIDTH         = 2;

  // Bit order equals the cause register layout, bit 9 first
  typedef struct packed {
    logic start_byte_without_restart;
    logic highspeed_without_restart;
    logic start_byte_acked;
    logic hs_master_code_acked;
    logic general_call_read_err;
    logic general_call_unacked;
    logic tx_byte_unacked;
    logic ten_bit_second_byte_unacked;
    logic ten_bit_first_byte_unacked;
    logic seven_bit_addr_unacked;
  } abort_events_t;

  typedef struct packed {
    logic tx;
    logic rx;
  } dma_req_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

endpackage

// ==== sim/dma_fifo_model.sv ====
/*
  Far side of the DMA request lines: a DMA controller that moves one entry
  per request cycle unless stalled, plus a bus engine that drains the
  transmit FIFO and fills the receive FIFO when told. Counts stay in 0..8.
  Assumes one clock, synchronous active-low reset, bench-driven stimulus.
*/
`timescale 1ns/1ps
module dma_fifo_model
  import abort_dma_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   reset_n,
  input  wire dma_req_t               dma_req,
  input  wire logic                   tx_drain,
  input  wire logic                   rx_fill,
  input  wire logic                   stall,
  output logic [COUNT_WIDTH-1:0]      tx_fifo_count,
  output logic [COUNT_WIDTH-1:0]      rx_fifo_count
);
  // Stall models a slow DMA controller that leaves requests pending
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      tx_fifo_count <= '0;
      rx_fifo_count <= '0;
    end
    else
    begin
      tx_fifo_count <= tx_fifo_count
        + COUNT_WIDTH'(dma_req.tx && !stall && tx_fifo_count < 4'h8)
        - COUNT_WIDTH'(tx_drain && tx_fifo_count != '0);
      rx_fifo_count <= rx_fifo_count
        + COUNT_WIDTH'(rx_fill && rx_fifo_count < 4'h8)
        - COUNT_WIDTH'(dma_req.rx && !stall && rx_fifo_count != '0);
    end
  end
endmodule

// ==== sim/tb.sv ====
/*
  Self-checking bench: a cycle model predicts every output and is compared
  each cycle. Assumes the partner model supplies the FIFO fill counts.
*/
`timescale 1ns/1ps
`define CHK(g, x) \
  begin \
    n_tests++; \
    if ((g) !== (x)) \
    begin \
      err_total++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x); \
    end \
  end
module tb;
  import abort_dma_pkg::*;
  logic                   sys_clk, reset_n, cause_lvl, clr_abort, all_clr, en, act;
  logic                   srx, drain, fill, stall, evt, nack_out, irq_out;
  logic                   live = 1'b0;
  logic                   exp_tx, exp_rx, exp_nack, exp_evt, exp_irq;
  reg_req_t               req;
  abort_events_t          ev;
  dma_req_t               dreq;
  logic [31:0]            rdata, exp_rd;
  logic [COUNT_WIDTH-1:0] tx_cnt, rx_cnt;
  int                     err_total, n_tests, cycles, k, op, e, refd;
  int                     cause, nack, dcr, txl, rxl, stat, mask;
  logic [7:0]             addrs [8] = '{8'h80, 8'h84, 8'h88, 8'h8C, 8'h90, 8'hB0, 8'hB4, 8'h94};

  abort_dma_ctrl DUT (.sys_clk(sys_clk), .reset_n(reset_n), .reg_req(req), .reg_rdata(rdata),
    .abort_events(ev), .sbyte_norestart_cause(cause_lvl), .abort_clear_read(clr_abort),
    .all_irq_clear_read(all_clr), .controller_enable(en), .slave_active(act),
    .slave_receiver(srx), .tx_fifo_count(tx_cnt), .rx_fifo_count(rx_cnt), .dma_req(dreq),
    .tx_abort_event(evt), .slave_data_nack(nack_out), .irq(irq_out));
  dma_fifo_model far_side (.sys_clk(sys_clk), .reset_n(reset_n), .dma_req(dreq),
    .tx_drain(drain), .rx_fill(fill), .stall(stall), .tx_fifo_count(tx_cnt),
    .rx_fifo_count(rx_cnt));

  always #25 sys_clk = ~sys_clk;

  task wrap_up;
    if (err_total == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task cyc(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d,
           input logic [9:0] evb, input logic c);
    @(posedge sys_clk);
    req <= '{a, d, w, r};
    ev <= abort_events_t'(evb);
    clr_abort <= c;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    cyc(1'b1, 1'b0, a, d, '0, 1'b0);
  endtask

  task rd(input logic [7:0] a);
    cyc(1'b0, 1'b1, a, '0, '0, 1'b0);
  endtask

  task pls(input logic [9:0] evb, input logic c);
    cyc(1'b0, 1'b0, 8'h00, '0, evb, c);
  endtask

  // Model sees the values sampled at this edge; bench updates land after it
  always @(posedge sys_clk)
  begin
    live = 1'b1;
    e = int'(ev);
    exp_tx = reset_n && dcr[1] && tx_cnt <= txl;
    exp_rx = reset_n && dcr[0] && rx_cnt >= rxl + 1;
    exp_nack = reset_n && nack[0] && srx;
    exp_evt = reset_n && e != 0;
    exp_irq = reset_n && (stat & mask) != 0;
    exp_rd = '0;
    if (reset_n && req.rd)
      case (req.addr)
        ABORT_CAUSE_OFS:   exp_rd = 32'(cause);
        SLV_NACK_CTRL_OFS: exp_rd = 32'(nack);
        DMA_CONTROL_OFS:   exp_rd = 32'(dcr);
        DMA_TX_LEVEL_OFS:  exp_rd = 32'(txl);
        DMA_RX_LEVEL_OFS:  exp_rd = 32'(rxl);
        IRQ_STATUS_OFS:    exp_rd = 32'(stat);
        IRQ_MASK_OFS:      exp_rd = 32'(mask);
        default:           exp_rd = '0;
      endcase
    if (!reset_n)
    begin
      cause = 0;
      nack = 0;
      dcr = 0;
      txl = 0;
      rxl = 0;
      stat = 0;
      mask = 0;
    end
    else
    begin
      refd = int'(req.wr && req.addr == SLV_NACK_CTRL_OFS && (en || act));
      if (req.wr && req.addr == IRQ_STATUS_OFS)
        stat = stat & ~int'(req.wdata);
      stat = stat | (refd << 1) | int'(e != 0);
      if (clr_abort || all_clr)
        cause = e & 'h1FF;
      else
        cause = cause | e | (cause_lvl ? 'h200 : 0);
      if (req.wr)
        case (req.addr)
          SLV_NACK_CTRL_OFS: nack = refd ? nack : int'(req.wdata[0]);
          DMA_CONTROL_OFS:   dcr = int'(req.wdata[1:0]);
          DMA_TX_LEVEL_OFS:  txl = int'(req.wdata[2:0]);
          DMA_RX_LEVEL_OFS:  rxl = int'(req.wdata[2:0]);
          IRQ_MASK_OFS:      mask = int'(req.wdata[1:0]);
          default:           ;
        endcase
    end
  end

  // One process owns the counters, so the timeout and the checks never race
  always @(negedge sys_clk)
  begin
    if (live)
    begin
      `CHK(rdata, exp_rd);
      `CHK(dreq.tx, exp_tx);
      `CHK(dreq.rx, exp_rx);
      `CHK(nack_out, exp_nack);
      `CHK(evt, exp_evt);
      `CHK(irq_out, exp_irq);
    end
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      wrap_up();
    end
  end

  initial
  begin
    {sys_clk, reset_n, cause_lvl, clr_abort, all_clr, en, act} = '0;
    {srx, drain, fill, stall} = '0;
    req = '0;
    ev = '0;
    void'($urandom(32'h9197));
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    pls('0, 1'b0);
    for (k = 0; k < 8; k++)
      rd(addrs[k]);
    wr(DMA_CONTROL_OFS, 32'h0000_0003);
    wr(DMA_TX_LEVEL_OFS, 32'hFFFF_FFFA);
    wr(DMA_RX_LEVEL_OFS, 32'h0000_0000);
    wr(IRQ_MASK_OFS, 32'h0000_0003);
    // Slave activity is low here, so this write must land
    wr(SLV_NACK_CTRL_OFS, 32'h0000_0001);
    // Level changes go into an idle cycle; en and act hold for the next write only, srx stays high
    pls('0, 1'b0);
    srx <= 1'b1;
    en <= 1'b1;
    wr(SLV_NACK_CTRL_OFS, 32'h0000_0000);
    pls('0, 1'b0);
    en <= 1'b0;
    act <= 1'b1;
    wr(SLV_NACK_CTRL_OFS, 32'h0000_0000);
    pls('0, 1'b0);
    act <= 1'b0;
    for (k = 0; k < 10; k++)
    begin
      pls(10'(1) << k, 1'b0);
      rd(ABORT_CAUSE_OFS);
      pls('0, 1'b1);
    end
    // Start byte cause still present when cleared
    pls(10'h200, 1'b0);
    cause_lvl <= 1'b1;
    pls('0, 1'b1);
    rd(ABORT_CAUSE_OFS);
    rd(ABORT_CAUSE_OFS);
    cause_lvl <= 1'b0;
    pls('0, 1'b1);
    repeat (3000)
    begin
      op = $urandom_range(0, 2);
      k = $urandom_range(0, 40);
      cyc(op == 1, op == 2, addrs[$urandom_range(0, 7)], $urandom,
          (k < 10) ? 10'(1) << k : '0, k == 40);
      all_clr <= k == 39;
      en <= $urandom_range(0, 3) == 0;
      act <= $urandom_range(0, 3) == 0;
      {srx, drain, fill, stall} <= 4'($urandom);
    end
    pls('0, 1'b0);
    pls('0, 1'b0);
    wrap_up();
  end
endmodule
